// [src/bse_exec.sv]
// execution unit for bit operations, compares, skips, indirect jumps and conditional branches
// assumes the decoder holds req stable only in the cycle req_valid is high and busy is low
`timescale 1ns/1ns

module bse_exec
  import bse_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // instruction request
  input wire logic req_valid,
  input wire bse_req_type req,
  // execution status
  output logic busy,
  output logic done,
  // results
  output bse_rsp_type rsp
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  bse_state_type state_r;
  bse_state_type state_nxt;
  bse_rsp_type rsp_c;
  logic take;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic [DATA_W-1:0] sr;
  logic [DATA_W-1:0] res;
  logic [DATA_W:0] diff;
  logic [DATA_W-1:0] dres;
  logic sub_h;
  logic sub_v;
  logic cond;
  logic skip;
  logic [PC_W-1:0] pc_inc;
  logic [PC_W-1:0] pc_rel;
  logic [PC_W-1:0] pc_skip;
  logic [CYC_W-1:0] cyc_skip;
  logic [CYC_W-1:0] cyc;

  // ----------------------------------------------------------------
  // flag helpers
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] upd_zn(
    input logic [DATA_W-1:0] s,
    input logic [DATA_W-1:0] r
  );
    logic [DATA_W-1:0] o;
    o = s;
    o[FLAG_Z] = (r == BYTE_ZERO);
    o[FLAG_N] = r[MSB];
    return o;
  endfunction : upd_zn

  // logic ops always clear overflow
  function automatic logic [DATA_W-1:0] upd_znv(
    input logic [DATA_W-1:0] s,
    input logic [DATA_W-1:0] r
  );
    logic [DATA_W-1:0] o;
    o = upd_zn(s, r);
    o[FLAG_V] = 1'b0;
    return o;
  endfunction : upd_znv

  // shifts: overflow is negative xor the new carry
  function automatic logic [DATA_W-1:0] upd_zcnv(
    input logic [DATA_W-1:0] s,
    input logic [DATA_W-1:0] r,
    input logic c
  );
    logic [DATA_W-1:0] o;
    o = upd_zn(s, r);
    o[FLAG_C] = c;
    o[FLAG_V] = r[MSB] ^ c;
    return o;
  endfunction : upd_zcnv

  // ----------------------------------------------------------------
  // shared datapath
  // ----------------------------------------------------------------
  assign take = req_valid && !state_r.busy;
  assign a = req.rd;
  assign b = req.rr;
  assign sr = req.status_register;
  assign pc_inc = req.pc + PC_ONE;

  // signed offset, sign extended to the counter width
  assign pc_rel = req.pc + {{(PC_W-OFS_W){req.offset[OFS_W-1]}}, req.offset} + PC_ONE;

  // a skipped two-word instruction costs one more cycle
  assign pc_skip = req.next_two_word ? req.pc + PC_SKIP_TWO : req.pc + PC_SKIP_ONE;
  assign cyc_skip = req.next_two_word ? CYC_THREE : CYC_TWO;

  // compare against the immediate
  assign diff = {1'b0, a} - {1'b0, req.imm};
  assign dres = diff[DATA_W-1:0];
  assign sub_h = (~a[HALF_BIT] & req.imm[HALF_BIT])
               | (req.imm[HALF_BIT] & dres[HALF_BIT])
               | (dres[HALF_BIT] & ~a[HALF_BIT]);
  assign sub_v = (a[MSB] & ~req.imm[MSB] & ~dres[MSB])
               | (~a[MSB] & req.imm[MSB] & dres[MSB]);

  // ----------------------------------------------------------------
  // branch condition
  // ----------------------------------------------------------------
  always_comb begin
    cond = 1'b0;
    unique case (req.op)
      branch_status_set_op: begin
        cond = sr[req.bit_sel];
      end
      branch_status_clear_op: begin
        cond = !sr[req.bit_sel];
      end
      branch_signed_ge_op: begin
        cond = !(sr[FLAG_N] ^ sr[FLAG_V]);
      end
      branch_signed_lt_op: begin
        cond = sr[FLAG_N] ^ sr[FLAG_V];
      end
      branch_unsigned_ge_op: begin
        cond = !sr[FLAG_C];
      end
      branch_unsigned_lt_op: begin
        cond = sr[FLAG_C];
      end
      branch_halfcarry_set_op: begin
        cond = sr[FLAG_H];
      end
      branch_halfcarry_clear_op: begin
        cond = !sr[FLAG_H];
      end
      branch_transfer_set_op: begin
        cond = sr[FLAG_T];
      end
      branch_transfer_clear_op: begin
        cond = !sr[FLAG_T];
      end
      branch_overflow_set_op: begin
        cond = sr[FLAG_V];
      end
      branch_overflow_clear_op: begin
        cond = !sr[FLAG_V];
      end
      branch_irq_enabled_op: begin
        cond = sr[FLAG_I];
      end
      branch_irq_disabled_op: begin
        cond = !sr[FLAG_I];
      end
      default: begin
        cond = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // skip condition
  // ----------------------------------------------------------------
  always_comb begin
    skip = 1'b0;
    unique case (req.op)
      compare_skip_equal_op: begin
        skip = (a == b);
      end
      skip_reg_bit_clear_op: begin
        skip = !b[req.bit_sel];
      end
      skip_reg_bit_set_op: begin
        skip = b[req.bit_sel];
      end
      skip_io_bit_clear_op: begin
        skip = !req.io_rdata[req.bit_sel];
      end
      skip_io_bit_set_op: begin
        skip = req.io_rdata[req.bit_sel];
      end
      default: begin
        skip = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // operation results
  // ----------------------------------------------------------------
  always_comb begin
    res = a;
    rsp_c.result = a;
    rsp_c.result_we = 1'b0;
    rsp_c.status_register = sr;
    rsp_c.pc_next = pc_inc;
    rsp_c.io_wdata = req.io_rdata;
    rsp_c.io_we = 1'b0;
    rsp_c.push_we = 1'b0;
    rsp_c.push_addr = pc_inc;
    cyc = CYC_ONE;
    unique case (req.op)
      set_bits_op: begin
        res = a | req.imm;
        rsp_c.result = res;
        rsp_c.result_we = 1'b1;
        rsp_c.status_register = upd_znv(sr, res);
      end
      clear_bits_op: begin
        res = a & (MASK_ALL - req.imm);
        rsp_c.result = res;
        rsp_c.result_we = 1'b1;
        rsp_c.status_register = upd_znv(sr, res);
      end
      test_zero_minus_op: begin
        // register left as is, only the flags move
        res = a & a;
        rsp_c.status_register = upd_znv(sr, res);
      end
      indirect_jump_op: begin
        rsp_c.pc_next = req.z_ptr;
        cyc = CYC_TWO;
      end
      indirect_call_op: begin
        // return address goes to the stack unit
        rsp_c.pc_next = req.z_ptr;
        rsp_c.push_we = 1'b1;
        cyc = CYC_THREE;
      end
      compare_immediate_op: begin
        rsp_c.status_register = upd_zn(sr, dres);
        rsp_c.status_register[FLAG_C] = diff[DATA_W];
        rsp_c.status_register[FLAG_V] = sub_v;
        rsp_c.status_register[FLAG_H] = sub_h;
      end
      compare_skip_equal_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
      skip_io_bit_clear_op, skip_io_bit_set_op: begin
        if (skip) begin
          rsp_c.pc_next = pc_skip;
          cyc = cyc_skip;
        end
      end
      branch_status_set_op, branch_status_clear_op,
      branch_signed_ge_op, branch_signed_lt_op,
      branch_unsigned_ge_op, branch_unsigned_lt_op,
      branch_halfcarry_set_op, branch_halfcarry_clear_op,
      branch_transfer_set_op, branch_transfer_clear_op,
      branch_overflow_set_op, branch_overflow_clear_op,
      branch_irq_enabled_op, branch_irq_disabled_op: begin
        if (cond) begin
          rsp_c.pc_next = pc_rel;
          cyc = CYC_TWO;
        end
      end
      io_bit_set_op: begin
        // only the chosen bit changes; the other bits write back what was read, so a write-one-to-clear neighbour reading 1 is cleared
        rsp_c.io_wdata[req.bit_sel] = 1'b1;
        rsp_c.io_we = 1'b1;
        cyc = CYC_TWO;
      end
      io_bit_clear_op: begin
        rsp_c.io_wdata[req.bit_sel] = 1'b0;
        rsp_c.io_we = 1'b1;
        cyc = CYC_TWO;
      end
      rotate_left_carry_op: begin
        res = {a[MSB-1:0], sr[FLAG_C]};
        rsp_c.result = res;
        rsp_c.result_we = 1'b1;
        rsp_c.status_register = upd_zcnv(sr, res, a[MSB]);
      end
      shift_left_op: begin
        res = {a[MSB-1:0], 1'b0};
        rsp_c.result = res;
        rsp_c.result_we = 1'b1;
        rsp_c.status_register = upd_zcnv(sr, res, a[MSB]);
      end
      shift_right_op: begin
        res = {1'b0, a[MSB:1]};
        rsp_c.result = res;
        rsp_c.result_we = 1'b1;
        rsp_c.status_register = upd_zcnv(sr, res, a[0]);
      end
      default: begin
        cyc = CYC_ONE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  // the result is computed at acceptance and held; done marks the last cycle
  always_comb begin
    state_nxt = state_r;
    state_nxt.done = 1'b0;
    unique case (state_r.fsm)
      ST_IDLE: begin
        if (take) begin
          state_nxt.rsp = rsp_c;
          if (cyc == CYC_ONE) begin
            state_nxt.done = 1'b1;
          end else begin
            state_nxt.busy = 1'b1;
            state_nxt.cnt = cyc - CYC_TWO;
            state_nxt.fsm = ST_EXEC;
          end
        end
      end
      ST_EXEC: begin
        if (state_r.cnt == '0) begin
          state_nxt.busy = 1'b0;
          state_nxt.done = 1'b1;
          state_nxt.fsm = ST_IDLE;
        end else begin
          state_nxt.cnt = state_r.cnt - CYC_ONE;
        end
      end
      default: begin
        state_nxt = STATE_RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign busy = state_r.busy;
  assign done = state_r.done;
  assign rsp = state_r.rsp;

endmodule : bse_exec

// [src/bse_pkg.sv]
// constants, opcodes and carrier types for the branch, skip and bit-operation execution unit
// assumes one core clock and a decoder that presents one instruction at a time
// Overview of operation
// - set bits: or with mask, znv, one cycle
// - clear bits: and with inverted mask, znv
// - test: and with itself, znv, no write
// - indirect jump loads pc from z, two cycles
// - indirect call loads pc from z, three cycles
// - skip next when registers equal, 1/2/3 cycles
// - compare immediate: subtract, flags only, one cycle
// - register bit skip, pc plus 2 or 3
// - io bit skip when bit clear or set
// - generic branch by chosen status bit polarity
// - signed ge branch when n xor v clear
// - signed lt branch when n xor v set
// - unsigned branches by carry clear or set
// - half carry branches by h set or clear
// - transfer bit branches by t set or clear
// - overflow branches by v set or clear
// - interrupt state branches by i flag
// - io bit set in two cycles, no flags
// - io bit clear in two cycles, no flags
// - rotate left through carry, zcnv, one cycle
package bse_pkg;

  // ----------------------------------------------------------------
  // widths and figures
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PC_W = 16;
  localparam int OFS_W = 7;
  localparam int BIT_W = 3;
  localparam int CYC_W = 2;
  localparam int MSB = 7;
  localparam int HALF_BIT = 3;

  localparam logic [DATA_W-1:0] MASK_ALL = 8'hff;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [PC_W-1:0] PC_ONE = 16'h0001;
  localparam logic [PC_W-1:0] PC_SKIP_ONE = 16'h0002;
  localparam logic [PC_W-1:0] PC_SKIP_TWO = 16'h0003;
  localparam logic [CYC_W-1:0] CYC_ONE = 2'h1;
  localparam logic [CYC_W-1:0] CYC_TWO = 2'h2;
  localparam logic [CYC_W-1:0] CYC_THREE = 2'h3;

  // ----------------------------------------------------------------
  // status register bit positions
  // ----------------------------------------------------------------
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    set_bits_op, clear_bits_op, test_zero_minus_op,
    indirect_jump_op, indirect_call_op,
    compare_skip_equal_op, compare_immediate_op,
    skip_reg_bit_clear_op, skip_reg_bit_set_op,
    skip_io_bit_clear_op, skip_io_bit_set_op,
    branch_status_set_op, branch_status_clear_op,
    branch_signed_ge_op, branch_signed_lt_op,
    branch_unsigned_ge_op, branch_unsigned_lt_op,
    branch_halfcarry_set_op, branch_halfcarry_clear_op,
    branch_transfer_set_op, branch_transfer_clear_op,
    branch_overflow_set_op, branch_overflow_clear_op,
    branch_irq_enabled_op, branch_irq_disabled_op,
    io_bit_set_op, io_bit_clear_op,
    rotate_left_carry_op, shift_left_op, shift_right_op
  } bse_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_EXEC = 2'b10
  } bse_fsm_type;

  typedef struct packed {
    bse_op_type op;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] rr;
    logic [DATA_W-1:0] imm;
    logic [BIT_W-1:0] bit_sel;
    logic [DATA_W-1:0] io_rdata;
    logic [PC_W-1:0] z_ptr;
    logic [PC_W-1:0] pc;
    logic [OFS_W-1:0] offset;
    logic next_two_word;
    logic [DATA_W-1:0] status_register;
  } bse_req_type;

  typedef struct packed {
    logic [DATA_W-1:0] result;
    logic result_we;
    logic [DATA_W-1:0] status_register;
    logic [PC_W-1:0] pc_next;
    logic [DATA_W-1:0] io_wdata;
    logic io_we;
    logic push_we;
    logic [PC_W-1:0] push_addr;
  } bse_rsp_type;

  typedef struct packed {
    bse_fsm_type fsm;
    logic [CYC_W-1:0] cnt;
    logic busy;
    logic done;
    bse_rsp_type rsp;
  } bse_state_type;

  localparam bse_state_type STATE_RST = '{
    fsm: ST_IDLE, cnt: '0, busy: 1'b0, done: 1'b0, rsp: '0};

endpackage : bse_pkg

// [tb/bse_exec_asserts.sv]
// checker for the branch, skip and bit-operation execution unit
// assumes it is bound to bse_exec and sees only that module's ports
`timescale 1ns/1ns

module bse_exec_asserts
  import bse_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // request
  input wire logic req_valid,
  input wire bse_req_type req,
  // answer
  input wire logic busy,
  input wire logic done,
  input wire bse_rsp_type rsp
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // a request only counts at an edge where the unit is free
  logic take;
  assign take = req_valid && !busy;

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_set_bits;
    take && req.op == set_bits_op |=> done && rsp.result_we && rsp.result == ($past(req.rd) | $past(req.imm));
  endproperty
  a_set_bits: assert property (p_set_bits) else $error("set bits result wrong");
  property p_clear_bits;
    take && req.op == clear_bits_op |=> done && rsp.result == ($past(req.rd) & (MASK_ALL - $past(req.imm)));
  endproperty
  a_clear_bits: assert property (p_clear_bits) else $error("clear bits result wrong");
  property p_test;
    take && req.op == test_zero_minus_op |=> done && !rsp.result_we && rsp.status_register[FLAG_N] == $past(req.rd[MSB]);
  endproperty
  a_test: assert property (p_test) else $error("test op wrote or bad sign");
  property p_indirect_jump_op;
    take && req.op == indirect_jump_op |=> busy && !done ##1 done && rsp.pc_next == $past(req.z_ptr, 2);
  endproperty
  a_indirect_jump_op: assert property (p_indirect_jump_op) else $error("indirect jump timing or target");
  property p_indirect_call_op;
    take && req.op == indirect_call_op |=> busy [*2] ##1 done && !busy && rsp.push_we && rsp.pc_next == $past(req.z_ptr, 3);
  endproperty
  a_indirect_call_op: assert property (p_indirect_call_op) else $error("indirect call timing or target");
  property p_cmp;
    take && req.op == compare_immediate_op |=> done && !rsp.result_we &&
      rsp.status_register[FLAG_C] == ($past(req.rd) < $past(req.imm));
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare borrow wrong");
  property p_branch_signed_ge_op;
    take && req.op == branch_signed_ge_op && !(req.status_register[FLAG_N] ^ req.status_register[FLAG_V]) |=>
      !done ##1 done && rsp.pc_next == $past(req.pc, 2) + {{9{$past(req.offset[6], 2)}}, $past(req.offset, 2)} + PC_ONE;
  endproperty
  a_branch_signed_ge_op: assert property (p_branch_signed_ge_op) else $error("signed ge branch not taken right");
  property p_branch_signed_lt_op;
    take && req.op == branch_signed_lt_op && !(req.status_register[FLAG_N] ^ req.status_register[FLAG_V]) |=>
      done && rsp.pc_next == $past(req.pc) + PC_ONE;
  endproperty
  a_branch_signed_lt_op: assert property (p_branch_signed_lt_op) else $error("signed lt branch wrongly taken");
  property p_io_set;
    take && req.op == io_bit_set_op |=> !done ##1 done && rsp.io_we &&
      rsp.io_wdata == ($past(req.io_rdata, 2) | (8'h01 << $past(req.bit_sel, 2)));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");
  property p_rol;
    take && req.op == rotate_left_carry_op |=> done && rsp.status_register[FLAG_C] == $past(req.rd[MSB]) &&
      rsp.result == {$past(req.rd[6:0]), $past(req.status_register[FLAG_C])};
  endproperty
  a_rol: assert property (p_rol) else $error("rotate through carry wrong");
endmodule : bse_exec_asserts

bind bse_exec bse_exec_asserts u_chk (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req(req),
  .busy(busy), .done(done), .rsp(rsp));

// [tb/testbench.sv]
// self-checking bench for the branch, skip and bit-operation execution unit
// assumes bse_exec alone, driven 1 ns after each rising edge of a 25 MHz clock
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, e, g); end end

module testbench
  import bse_pkg::*;
;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  bse_req_type req = '0;
  logic busy;
  logic done;
  bse_rsp_type rsp;
  int error_cnt = 0;
  int checks = 0;
  int cyc;

  always #20 clk_sys = ~clk_sys;

  bse_exec dut (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid), .req(req), .busy(busy), .done(done),
    .rsp(rsp));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // hold keeps a different request pending while busy, which must be ignored
  task automatic go(input logic hold);
    @(posedge clk_sys);
    #1 req_valid = 1'b1;
    @(posedge clk_sys);
    #1 req_valid = hold;
    if (hold) req.op = set_bits_op;
    cyc = 1;
    while (done !== 1'b1 && cyc < 8) begin
      @(posedge clk_sys);
      #1 cyc++;
    end
    // only a held request is still up here; hold is used with multi-cycle ops only
    if (hold) req_valid = 1'b0;
  endtask : go

  task automatic one(input bse_op_type op, input logic [7:0] rd, imm, sin, res, input logic we, input logic [7:0] sout);
    req = '0;
    req.op = op;
    req.rd = rd;
    req.imm = imm;
    req.status_register = sin;
    go(1'b0);
    `CHK("cycles", 1, cyc)
    `CHK("write", we, rsp.result_we)
    if (we) `CHK("result", res, rsp.result)
    `CHK("flags", sout, rsp.status_register)
  endtask : one

  function automatic logic taken(bse_op_type op, logic [7:0] sr, logic [2:0] bs);
    case (op)
      branch_status_set_op: return sr[bs];
      branch_status_clear_op: return !sr[bs];
      branch_signed_ge_op: return !(sr[FLAG_N] ^ sr[FLAG_V]);
      branch_signed_lt_op: return sr[FLAG_N] ^ sr[FLAG_V];
      branch_unsigned_ge_op: return !sr[FLAG_C];
      branch_unsigned_lt_op: return sr[FLAG_C];
      branch_halfcarry_set_op: return sr[FLAG_H];
      branch_halfcarry_clear_op: return !sr[FLAG_H];
      branch_transfer_set_op: return sr[FLAG_T];
      branch_transfer_clear_op: return !sr[FLAG_T];
      branch_overflow_set_op: return sr[FLAG_V];
      branch_overflow_clear_op: return !sr[FLAG_V];
      branch_irq_enabled_op: return sr[FLAG_I];
      default: return !sr[FLAG_I];
    endcase
  endfunction : taken

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_alu();
    one(set_bits_op, 8'h81, 8'h12, 8'h18, 8'h93, 1'b1, 8'h14);
    one(clear_bits_op, 8'h0f, 8'h0f, 8'h08, 8'h00, 1'b1, 8'h02);
    one(test_zero_minus_op, 8'h80, 8'h00, 8'h0a, 8'h80, 1'b0, 8'h04);
    one(test_zero_minus_op, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h02);
    one(compare_immediate_op, 8'h10, 8'h20, 8'h00, 8'h00, 1'b0, 8'h05);
    one(compare_immediate_op, 8'h10, 8'h01, 8'h00, 8'h00, 1'b0, 8'h20);
    one(compare_immediate_op, 8'h80, 8'h01, 8'h00, 8'h00, 1'b0, 8'h28);
    one(rotate_left_carry_op, 8'h81, 8'h00, 8'h01, 8'h03, 1'b1, 8'h09);
    one(shift_left_op, 8'hc0, 8'h00, 8'h01, 8'h80, 1'b1, 8'h05);
    one(shift_right_op, 8'h01, 8'h00, 8'h01, 8'h00, 1'b1, 8'h0b);
    $display("test alu done");
  endtask : t_alu

  task automatic t_jump();
    req = '0;
    req.op = indirect_jump_op;
    req.z_ptr = 16'h1234;
    req.pc = 16'h0040;
    req.status_register = 8'h5a;
    go(1'b0);
    `CHK("cycles", 2, cyc)
    `CHK("pc", 16'h1234, rsp.pc_next)
    `CHK("flags", 8'h5a, rsp.status_register)
    `CHK("push", 1'b0, rsp.push_we)
    req.op = indirect_call_op;
    req.z_ptr = 16'h0abc;
    go(1'b1);
    `CHK("cycles", 3, cyc)
    `CHK("pc", 16'h0abc, rsp.pc_next)
    `CHK("push", 1'b1, rsp.push_we)
    `CHK("ret", 16'h0041, rsp.push_addr)
    `CHK("flags", 8'h5a, rsp.status_register)
    @(posedge clk_sys);
    #1 `CHK("done", 1'b0, done)
    $display("test jump done");
  endtask : t_jump

  task automatic t_skip();
    bse_op_type ops [5] = '{compare_skip_equal_op, skip_reg_bit_clear_op, skip_reg_bit_set_op,
      skip_io_bit_clear_op, skip_io_bit_set_op};
    logic s, io, p;
    logic [7:0] pat;
    int n;
    for (int k = 0; k < 15; k++) begin
      s = (k % 3) != 2;
      req = '0;
      req.op = ops[k / 3];
      req.next_two_word = (k % 3) == 0;
      req.pc = 16'h0200;
      req.rd = 8'h5a;
      req.bit_sel = 3'h6;
      req.status_register = 8'h3c;
      io = req.op inside {skip_io_bit_clear_op, skip_io_bit_set_op};
      p = (req.op inside {skip_reg_bit_set_op, skip_io_bit_set_op}) ? s : !s;
      pat = p ? 8'h40 : 8'hbf;
      req.rr = (req.op == compare_skip_equal_op) ? (s ? 8'h5a : 8'ha5) : (io ? ~pat : pat);
      req.io_rdata = io ? pat : ~pat;
      n = s ? (req.next_two_word ? 3 : 2) : 1;
      go(1'b0);
      `CHK("cycles", n, cyc)
      `CHK("pc", 16'h0200 + 16'(n), rsp.pc_next)
      `CHK("flags", 8'h3c, rsp.status_register)
    end
    $display("test skip done");
  endtask : t_skip

  task automatic t_branch();
    logic [7:0] srs [3] = '{8'h00, 8'hff, 8'h04};
    logic t;
    for (int i = 11; i < 25; i++) begin
      for (int j = 0; j < 3; j++) begin
        req = '0;
        req.op = bse_op_type'(5'(i));
        req.pc = 16'h0100;
        req.offset = (j == 1) ? 7'h3f : 7'h7e;
        req.bit_sel = 3'(i);
        req.status_register = srs[j];
        t = taken(req.op, srs[j], req.bit_sel);
        go(1'b0);
        `CHK("cycles", t ? 2 : 1, cyc)
        `CHK("pc", t ? 16'h0101 + {{9{req.offset[6]}}, req.offset} : 16'h0101, rsp.pc_next)
        `CHK("flags", srs[j], rsp.status_register)
      end
    end
    $display("test branch done");
  endtask : t_branch

  task automatic io_one(input bse_op_type op, input logic [7:0] rdata, input logic [2:0] bs, input logic [7:0] wexp);
    req = '0;
    req.op = op;
    req.io_rdata = rdata;
    req.bit_sel = bs;
    req.status_register = 8'h81;
    go(1'b0);
    `CHK("cycles", 2, cyc)
    `CHK("io write", 1'b1, rsp.io_we)
    `CHK("io data", wexp, rsp.io_wdata)
    `CHK("flags", 8'h81, rsp.status_register)
  endtask : io_one

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    #1 resetn = 1'b1;
    `CHK("busy", 1'b0, busy)
    `CHK("done", 1'b0, done)
    `CHK("rsp", '0, rsp)
    t_alu();
    t_jump();
    t_skip();
    t_branch();
    io_one(io_bit_set_op, 8'h15, 3'h7, 8'h95);
    io_one(io_bit_clear_op, 8'hff, 3'h0, 8'hfe);
    $display("test io done");
    wrap_up();
  end

  // 71 operations of at most 5 cycles each; this is several times that
  initial begin
    #100000;
    error_cnt++;
    $display("BAD watchdog exp finish got hang");
    wrap_up();
  end
endmodule : testbench
